// [rtl/esp_pkg.sv]
package esp_pkg;
	// Core clock rate
	localparam int CLK_KHZ = 10000;
	// Link clock limits and the rate asked for
	localparam int LINK_MIN_KHZ = 100;
	localparam int LINK_STD_MAX_KHZ = 2000;
	localparam int LINK_COMP_MAX_KHZ = 16000;
	localparam int TCAL_RATE_MAX_KHZ = 8000;
	localparam int LINK_REQ_KHZ = 1000;
	localparam bit LINK_COMPENSATED = 1'b0;
	localparam bit LINK_INCR_CABLE = 1'b1;
	localparam bit ENC_RATE_IN_MEM = 1'b0;
	// Highest rate allowed for this wiring
	localparam int LINK_MAX_KHZ = (LINK_COMPENSATED && !LINK_INCR_CABLE && ENC_RATE_IN_MEM)
		? LINK_COMP_MAX_KHZ : LINK_STD_MAX_KHZ;
	localparam int LINK_KHZ = (LINK_REQ_KHZ > LINK_MAX_KHZ) ? LINK_MAX_KHZ :
		((LINK_REQ_KHZ < LINK_MIN_KHZ) ? LINK_MIN_KHZ : LINK_REQ_KHZ);
	// Half period in core cycles, rounded up so the rate never exceeds the limit
	localparam int HALF_DIV = (CLK_KHZ + 2 * LINK_KHZ - 1) / (2 * LINK_KHZ);
	// Least wait before answering, in half pulses and in whole rising edges
	localparam int CAL_HALF_PULSES = 29;
	localparam int CAL_EDGES = (CAL_HALF_PULSES + 1) / 2;
	// Calculation time and link recovery time
	localparam int TCAL_NS = 5000;
	localparam int TCAL_CYC = (TCAL_NS * CLK_KHZ + 999999) / 1000000;
	localparam int RECOV_NS = 3000;
	localparam int RECOV_CYC = (RECOV_NS * CLK_KHZ + 999999) / 1000000;
	localparam int GAP_MARGIN_CYC = 8;
	localparam int WAIT_MAX_EDGES = 40;
	// Field widths
	localparam int CMD_W = 8;
	localparam int MODE_W = 6;
	localparam int SEL_W = 2;
	localparam int PARAM_W = 24;
	localparam int DATA_W = 16;
	localparam int ST_W = 8;
	localparam int ITEM_W = ST_W + DATA_W;
	localparam int POS_BITS = 20;
	localparam int PBITS_W = 6;
	localparam int CNT_W = 7;
	localparam int TMR_W = 8;
	localparam int FIFO_W = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int MEM_DEPTH = 16;
	localparam int MEM_AW = 4;
	// Parameter word layout
	localparam int PRM_WR_BIT = 23;
	localparam int PRM_ADDR_LSB = 16;
	// Mode command codes
	localparam logic [5:0] MODE_POS = 6'h01;
	localparam logic [5:0] MODE_MEM_RD = 6'h02;
	localparam logic [5:0] MODE_MEM_WR = 6'h03;
	localparam logic [5:0] MODE_POS_ADD = 6'h04;
	localparam logic [5:0] MODE_ERR_CLR = 6'h05;
	// Status byte bit positions
	localparam int ST_WARN = 7;
	localparam int ST_REF = 6;
	localparam int ST_BUSY = 5;
	// Memory map and reset contents
	localparam logic [3:0] MEM_POS_BITS = 4'h0;
	localparam logic [3:0] MEM_CMD_SET = 4'h1;
	localparam logic [3:0] MEM_MAX_KHZ = 4'h2;
	localparam logic [3:0] MEM_INTERP = 4'h3;
	localparam logic [3:0] MEM_PROT_LAST = 4'h7;
	localparam logic [15:0] CMD_SET_OLDER = 16'h0000;
	localparam logic [15:0] CMD_SET_NEWER = 16'h0001;
	localparam logic [15:0] INTERP_X2 = 16'h0061;
	localparam logic [15:0] INTERP_X1 = 16'h0062;
	localparam logic [15:0] INTERP_HALF = 16'h0063;
	// Word layout towards the user
	localparam int W_ERR_BIT = 31;
	localparam int W_KIND_LSB = 29;
	localparam logic [1:0] KIND_POS = 2'h0;
	localparam logic [1:0] KIND_ADD1 = 2'h1;
	localparam logic [1:0] KIND_ADD2 = 2'h2;
	localparam logic [1:0] KIND_MEM = 2'h3;

	// Commands only the newer set knows
	function automatic logic mode_is_newer(input logic [5:0] m);
		return (m == MODE_POS_ADD) || (m == MODE_ERR_CLR);
	endfunction

	function automatic logic mode_known(input logic [5:0] m);
		return (m >= MODE_POS) && (m <= MODE_ERR_CLR);
	endfunction

	// Commands followed by a parameter word
	function automatic logic mode_has_param(input logic [5:0] m);
		return (m == MODE_MEM_RD) || (m == MODE_MEM_WR) || (m == MODE_POS_ADD);
	endfunction
endpackage

// [rtl/esp_link_if.sv]
`timescale 1ns/1ns
// Four wires reduced to clock plus one shared data line
interface esp_link_if;
	logic link_clk;
	logic m_do;
	logic m_oe;
	logic e_do;
	logic e_oe;
	logic data_line;
	// Encoder drive wins; an undriven line idles low, so a released line
	// is never mistaken by the master for the start bit of an answer
	assign data_line = e_oe ? e_do : (m_oe ? m_do : 1'b0);
	modport master (output link_clk, output m_do, output m_oe, input data_line);
	modport encoder (input link_clk, input data_line, output e_do, output e_oe);
endinterface

// [rtl/esp_fifo.sv]
`timescale 1ns/1ns
module esp_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	// Drain side
	input wire logic out_ready_in,
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0] count_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_q [DEPTH]; // Storage words
	logic [W-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d; // Indices
	logic [CW-1:0] cnt_q, cnt_d; // Fill level
	logic push, pop;

	assign in_ready_out = (cnt_q != CW'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign count_out = cnt_q;
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	// Index wrap that also works for depths that are not a power of two
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data_in;
			wr_d = nxt(wr_q);
		end
		if (pop) begin
			rd_d = nxt(rd_q);
		end
		// Simultaneous push and pop leave the level alone
		if (push && !pop) begin
			cnt_d = CW'(cnt_q + 1'b1);
		end else if (pop && !push) begin
			cnt_d = CW'(cnt_q - 1'b1);
		end
	end

	// Registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mem_q <= '{default: '0};
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // esp_fifo

// [rtl/esp_encoder.sv]
`timescale 1ns/1ns
module esp_encoder
	import esp_pkg::*;
#(
	parameter logic NEWER_SET = 1'b1,
	parameter logic [15:0] INTERP_LETTER = INTERP_X1
) (
	// Core clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Link towards the master
	esp_link_if.encoder link,
	// Sensor side
	input wire logic step_in,
	input wire logic dir_pos_in,
	input wire logic warn_in,
	input wire logic ref_mark_in,
	input wire logic factory_unlock_in,
	// Status
	output logic cmd_err_out,
	output logic busy_out
);
	localparam int OUT_W = 2 + POS_BITS + 2 * ITEM_W;

	typedef enum logic [2:0] {E_IDLE, E_CMD, E_PARAM, E_WAIT, E_SEND} esp_enc_state_t;

	////////////////////////////////////////////////////////////////////////
	// Link synchronisers
	logic lc_s1_q, lc_s2_q, lc_s3_q; // Link clock stages
	logic dt_s1_q, dt_s2_q; // Data line stages
	logic rise, fall;

	// Two stages before any logic looks at a pin
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lc_s1_q <= 1'b1;
			lc_s2_q <= 1'b1;
			lc_s3_q <= 1'b1;
			dt_s1_q <= 1'b1;
			dt_s2_q <= 1'b1;
		end else begin
			lc_s1_q <= link.link_clk;
			lc_s2_q <= lc_s1_q;
			lc_s3_q <= lc_s2_q;
			dt_s1_q <= link.data_line;
			dt_s2_q <= dt_s1_q;
		end
	end

	// Edges of the master's clock pace the link bits; calculation and recovery times count core cycles
	assign rise = lc_s2_q & ~lc_s3_q;
	assign fall = ~lc_s2_q & lc_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Frame and memory state
	esp_enc_state_t st_q, st_d; // Frame state
	logic [CMD_W-1:0] cmd_q, cmd_d; // Received mode command
	logic [PARAM_W-1:0] prm_q, prm_d; // Received parameter word
	logic [CNT_W-1:0] bit_q, bit_d; // Bits of the current field
	logic [CNT_W-1:0] edge_q, edge_d; // Rising edges in this frame
	logic [TMR_W-1:0] tcal_q, tcal_d; // Calculation timer
	logic [TMR_W-1:0] recov_q, recov_d; // Clock-high timer
	logic [OUT_W-1:0] out_q, out_d; // Answer shift register
	logic [CNT_W-1:0] left_q, left_d; // Answer bits still to send
	logic oe_q, oe_d; // Data line drive
	logic err_q, err_d; // Sticky command error
	logic wr_pend_q, wr_pend_d; // Memory write waiting for frame end
	logic prot_q, prot_d; // Write protection of the low area
	logic ref_q, ref_d; // Reference mark seen, not yet reported
	logic [POS_BITS-1:0] pos_q, pos_d; // Live position
	logic [POS_BITS-1:0] lat_q, lat_d; // Position latched at request
	logic [DATA_W-1:0] stamp_q, stamp_d; // Free running timestamp
	logic [DATA_W-1:0] mem_q [MEM_DEPTH]; // Parameter memory
	logic [DATA_W-1:0] mem_d [MEM_DEPTH];
	logic [MODE_W-1:0] mode;
	logic [MEM_AW-1:0] addr;
	logic [ST_W-1:0] status;
	logic [1:0] items;
	logic reported;

	assign mode = cmd_q[CMD_W-1 -: MODE_W];
	assign addr = prm_q[PRM_ADDR_LSB +: MEM_AW];
	assign cmd_err_out = err_q;
	assign busy_out = wr_pend_q;
	assign link.e_do = out_q[OUT_W-1];
	assign link.e_oe = oe_q;

	// Status byte sent ahead of every additional item
	always_comb begin
		status = '0;
		status[ST_WARN] = warn_in;
		status[ST_REF] = ref_q;
		status[ST_BUSY] = wr_pend_q;
	end

	// Item count from the selector; an erroneous request gets none
	always_comb begin
		items = 2'd0;
		if (!err_q && mode == MODE_POS_ADD) begin
			items = (cmd_q[SEL_W-1:0] == 2'd0) ? 2'd0 :
				((cmd_q[SEL_W-1:0] == 2'd1) ? 2'd1 : 2'd2);
		end
	end

	// Next values of the whole frame and memory group
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		prm_d = prm_q;
		bit_d = bit_q;
		edge_d = edge_q;
		tcal_d = tcal_q;
		out_d = out_q;
		left_d = left_q;
		oe_d = oe_q;
		err_d = err_q;
		wr_pend_d = wr_pend_q;
		prot_d = prot_q;
		lat_d = lat_q;
		mem_d = mem_q;
		reported = 1'b0;
		// Position counts up when moving the positive way
		pos_d = pos_q;
		if (step_in) begin
			pos_d = dir_pos_in ? POS_BITS'(pos_q + 1'b1) : POS_BITS'(pos_q - 1'b1);
		end
		stamp_d = DATA_W'(stamp_q + 1'b1);
		// Only the manufacturer strap lifts protection; nothing on the link can
		if (factory_unlock_in) begin
			prot_d = 1'b0;
		end
		// A clock held high ends the frame, whatever state it stopped in
		recov_d = lc_s2_q ? ((recov_q == TMR_W'(RECOV_CYC)) ? recov_q : TMR_W'(recov_q + 1'b1))
			: '0;
		if (tcal_q != '0) begin
			tcal_d = TMR_W'(tcal_q - 1'b1);
		end
		if (rise) begin
			edge_d = (edge_q == '1) ? edge_q : CNT_W'(edge_q + 1'b1);
		end
		case (st_q)
			// Waiting for the first falling edge of a frame
			E_IDLE: begin
				oe_d = 1'b0;
				if (fall) begin
					st_d = E_CMD;
					bit_d = '0;
					edge_d = '0;
				end
			end
			// Shift in the mode command on rising edges
			E_CMD: begin
				if (rise) begin
					cmd_d = {cmd_q[CMD_W-2:0], dt_s2_q};
					bit_d = CNT_W'(bit_q + 1'b1);
					if (bit_q == CNT_W'(CMD_W - 1)) begin
						bit_d = '0;
						// Command ends here: snapshot position and start the timer
						lat_d = pos_q;
						tcal_d = TMR_W'(TCAL_CYC);
						st_d = mode_has_param(cmd_d[CMD_W-1 -: MODE_W]) ? E_PARAM : E_WAIT;
						// Unknown codes and newer-only codes on an older device
						if (!mode_known(cmd_d[CMD_W-1 -: MODE_W]) ||
							(mode_is_newer(cmd_d[CMD_W-1 -: MODE_W]) && !NEWER_SET)) begin
							err_d = 1'b1;
						end else if (cmd_d[CMD_W-1 -: MODE_W] == MODE_ERR_CLR) begin
							err_d = 1'b0;
						end
					end
				end
			end
			// Parameter word for memory access or a function with position
			E_PARAM: begin
				if (rise) begin
					prm_d = {prm_q[PARAM_W-2:0], dt_s2_q};
					bit_d = CNT_W'(bit_q + 1'b1);
					if (bit_q == CNT_W'(PARAM_W - 1)) begin
						st_d = E_WAIT;
						tcal_d = TMR_W'(TCAL_CYC);
						// Writes are held until the frame ends; busy shows meanwhile
						if (!err_q && (mode == MODE_MEM_WR ||
							(mode == MODE_POS_ADD && prm_d[PRM_WR_BIT]))) begin
							wr_pend_d = 1'b1;
						end
					end
				end
			end
			// Hold off until calculation time and the least pulse count
			E_WAIT: begin
				if (fall && tcal_q == '0 && edge_q >= CNT_W'(CAL_EDGES)) begin
					st_d = E_SEND;
					oe_d = 1'b1;
					// Answer kind follows the mode command; while an error stands, a position answer
					if (!err_q && (mode == MODE_MEM_RD || mode == MODE_MEM_WR)) begin
						out_d = {1'b1, err_q, mem_q[addr], (OUT_W - 2 - DATA_W)'(0)};
						if (mode == MODE_MEM_WR) begin
							out_d[OUT_W-3 -: DATA_W] = prm_q[DATA_W-1:0];
						end
						left_d = CNT_W'(1 + DATA_W);
					end else begin
						// Only the resolution's bits, then any selected items
						out_d = {1'b1, err_q, lat_q, status, mem_q[addr], status, stamp_q};
						left_d = CNT_W'(1 + POS_BITS + ITEM_W * int'(items));
						reported = (items != 2'd0);
					end
				end
			end
			// One bit per falling edge, start bit first
			E_SEND: begin
				if (fall) begin
					if (left_q == '0) begin
						oe_d = 1'b0;
						st_d = E_IDLE;
					end else begin
						out_d = {out_q[OUT_W-2:0], 1'b0};
						left_d = CNT_W'(left_q - 1'b1);
					end
				end
			end
			default: begin
				st_d = E_IDLE;
			end
		endcase
		// Frame end: release the line and carry out the deferred write
		if (st_q != E_IDLE && recov_q == TMR_W'(RECOV_CYC)) begin
			st_d = E_IDLE;
			oe_d = 1'b0;
			if (wr_pend_q) begin
				wr_pend_d = 1'b0;
				// Protected words keep their value while the lock stands
				if (addr > MEM_PROT_LAST || !prot_q) begin
					mem_d[addr] = prm_q[DATA_W-1:0];
				end
			end
		end
		// A new mark beats the clear that a report would cause
		ref_d = ref_mark_in | (ref_q & ~reported);
	end

	// Registers; memory resets to the device description words
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= E_IDLE;
			cmd_q <= '0;
			prm_q <= '0;
			bit_q <= '0;
			edge_q <= '0;
			tcal_q <= '0;
			recov_q <= '0;
			out_q <= '0;
			left_q <= '0;
			oe_q <= 1'b0;
			err_q <= 1'b0;
			wr_pend_q <= 1'b0;
			prot_q <= 1'b1;
			ref_q <= 1'b0;
			pos_q <= '0;
			lat_q <= '0;
			stamp_q <= '0;
			mem_q <= '{default: '0};
			mem_q[MEM_POS_BITS] <= DATA_W'(POS_BITS);
			mem_q[MEM_CMD_SET] <= NEWER_SET ? CMD_SET_NEWER : CMD_SET_OLDER;
			mem_q[MEM_MAX_KHZ] <= DATA_W'(LINK_MAX_KHZ);
			mem_q[MEM_INTERP] <= INTERP_LETTER;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			prm_q <= prm_d;
			bit_q <= bit_d;
			edge_q <= edge_d;
			tcal_q <= tcal_d;
			recov_q <= recov_d;
			out_q <= out_d;
			left_q <= left_d;
			oe_q <= oe_d;
			err_q <= err_d;
			wr_pend_q <= wr_pend_d;
			prot_q <= prot_d;
			ref_q <= ref_d;
			pos_q <= pos_d;
			lat_q <= lat_d;
			stamp_q <= stamp_d;
			mem_q <= mem_d;
		end
	end
endmodule // esp_encoder

// [rtl/esp_master.sv]
`timescale 1ns/1ns
module esp_master
	import esp_pkg::*;
(
	// Core clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Link towards the encoder
	esp_link_if.master link,
	// Request side
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [MODE_W-1:0] req_mode_in,
	input wire logic [SEL_W-1:0] req_sel_in,
	input wire logic [PARAM_W-1:0] req_param_in,
	input wire logic [PBITS_W-1:0] pos_bits_in,
	// Received words
	output logic rsp_valid_out,
	input wire logic rsp_ready_in,
	output logic [FIFO_W-1:0] rsp_data_out
);
	typedef enum logic [2:0] {M_IDLE, M_CMD, M_WAIT, M_RECV, M_GAP} esp_mst_state_t;

	esp_mst_state_t st_q, st_d; // Frame state
	logic [TMR_W-1:0] div_q, div_d; // Half period divider / gap timer
	logic clk_q, clk_d; // Link clock out
	logic do_q, do_d, oe_q, oe_d; // Data line drive
	logic [CMD_W+PARAM_W-1:0] tx_q, tx_d; // Request shift register
	logic [CNT_W-1:0] cnt_q, cnt_d; // Bits still to send or edges waited
	logic [CNT_W-1:0] seg_q, seg_d; // Bits left in the current field
	logic [1:0] items_q, items_d; // Items still expected
	logic [1:0] kind_q, kind_d; // Kind of the current field
	logic mem_q, mem_d; // Memory answer expected
	logic err_q, err_d; // Error bit of this answer
	logic [PARAM_W-1:0] acc_q, acc_d; // Field collector
	logic pend_q, pend_d; // Word waiting for the FIFO
	logic [FIFO_W-1:0] word_q, word_d;
	logic dt_s1_q, dt_s2_q; // Data line synchroniser
	logic tick, room, fifo_ready;
	logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_cnt;

	assign link.link_clk = clk_q;
	assign link.m_do = do_q;
	assign link.m_oe = oe_q;
	assign tick = (div_q == TMR_W'(HALF_DIV - 1));
	// Start only with room for a full answer, so the drain can stall us
	assign room = (int'(fifo_cnt) <= FIFO_DEPTH - 3);
	assign req_ready_out = (st_q == M_IDLE) && room && !pend_q;

	// Answers queue here until the user takes them
	esp_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.in_valid_in(pend_q),
		.in_ready_out(fifo_ready),
		.in_data_in(word_q),
		.out_ready_in(rsp_ready_in),
		.out_valid_out(rsp_valid_out),
		.out_data_out(rsp_data_out),
		.count_out(fifo_cnt)
	);

	// Data line comes from the encoder's domain
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dt_s1_q <= 1'b1;
			dt_s2_q <= 1'b1;
		end else begin
			dt_s1_q <= link.data_line;
			dt_s2_q <= dt_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next values; falls drive and sample, rises only raise the clock
	always_comb begin
		st_d = st_q;
		div_d = (st_q == M_IDLE) ? '0 : (tick ? '0 : TMR_W'(div_q + 1'b1));
		clk_d = clk_q;
		do_d = do_q;
		oe_d = oe_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		seg_d = seg_q;
		items_d = items_q;
		kind_d = kind_q;
		mem_d = mem_q;
		err_d = err_q;
		acc_d = acc_q;
		word_d = word_q;
		pend_d = pend_q & ~fifo_ready;
		case (st_q)
			// Writes go out only when the user asks, never on a timer
			M_IDLE: begin
				clk_d = 1'b1;
				if (req_valid_in && req_ready_out) begin
					st_d = M_CMD;
					tx_d = {req_mode_in, req_sel_in, req_param_in};
					cnt_d = mode_has_param(req_mode_in) ? CNT_W'(CMD_W + PARAM_W) : CNT_W'(CMD_W);
					mem_d = (req_mode_in == MODE_MEM_RD) || (req_mode_in == MODE_MEM_WR);
					items_d = (req_mode_in != MODE_POS_ADD) ? 2'd0 :
						((req_sel_in == 2'd3) ? 2'd2 : req_sel_in);
				end
			end
			// Drive one request bit per falling edge, then let go
			M_CMD: begin
				if (tick) begin
					clk_d = ~clk_q;
					if (clk_q) begin
						if (cnt_q != '0) begin
							do_d = tx_q[CMD_W+PARAM_W-1];
							oe_d = 1'b1;
							tx_d = {tx_q[CMD_W+PARAM_W-2:0], 1'b0};
							cnt_d = CNT_W'(cnt_q - 1'b1);
						end else begin
							oe_d = 1'b0;
							st_d = M_WAIT;
						end
					end
				end
			end
			// Keep clocking until the start bit shows up
			M_WAIT: begin
				if (tick) begin
					clk_d = ~clk_q;
					if (clk_q) begin
						cnt_d = CNT_W'(cnt_q + 1'b1);
						if (dt_s2_q) begin
							st_d = M_RECV;
							seg_d = '0;
							cnt_d = '0;
						end else if (cnt_q == CNT_W'(WAIT_MAX_EDGES)) begin
							// No answer: report an error word and close the frame
							pend_d = 1'b1;
							word_d = '0;
							word_d[W_ERR_BIT] = 1'b1;
							st_d = M_GAP;
							clk_d = 1'b1;
						end
					end
				end
			end
			// Collect error bit, then position or memory word, then items
			M_RECV: begin
				if (tick) begin
					clk_d = ~clk_q;
					if (clk_q) begin
						if (cnt_q == '0) begin
							cnt_d = CNT_W'(1);
							err_d = dt_s2_q;
							acc_d = '0;
							seg_d = mem_q ? CNT_W'(DATA_W) : CNT_W'(pos_bits_in);
							kind_d = mem_q ? KIND_MEM : KIND_POS;
						end else begin
							acc_d = {acc_q[PARAM_W-2:0], dt_s2_q};
							seg_d = CNT_W'(seg_q - 1'b1);
							if (seg_q == CNT_W'(1)) begin
								pend_d = 1'b1;
								word_d = {err_q, kind_q, 5'h00, acc_d};
								acc_d = '0;
								if (items_q != 2'd0) begin
									items_d = 2'(items_q - 1'b1);
									seg_d = CNT_W'(ITEM_W);
									kind_d = (kind_q == KIND_POS) ? KIND_ADD1 : KIND_ADD2;
								end else begin
									// Whole answer in: stop with the clock high
									st_d = M_GAP;
									clk_d = 1'b1;
								end
							end
						end
					end
				end
			end
			// Clock held high long enough for the encoder to recover
			M_GAP: begin
				clk_d = 1'b1;
				oe_d = 1'b0;
				div_d = TMR_W'(div_q + 1'b1);
				if (div_q == TMR_W'(RECOV_CYC + GAP_MARGIN_CYC)) begin
					st_d = M_IDLE;
				end
			end
			default: begin
				st_d = M_IDLE;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= M_IDLE;
			div_q <= '0;
			clk_q <= 1'b1;
			do_q <= 1'b1;
			oe_q <= 1'b0;
			tx_q <= '0;
			cnt_q <= '0;
			seg_q <= '0;
			items_q <= '0;
			kind_q <= KIND_POS;
			mem_q <= 1'b0;
			err_q <= 1'b0;
			acc_q <= '0;
			pend_q <= 1'b0;
			word_q <= '0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			clk_q <= clk_d;
			do_q <= do_d;
			oe_q <= oe_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			seg_q <= seg_d;
			items_q <= items_d;
			kind_q <= kind_d;
			mem_q <= mem_d;
			err_q <= err_d;
			acc_q <= acc_d;
			pend_q <= pend_d;
			word_q <= word_d;
		end
	end
endmodule // esp_master

// [dv/esp_link_checker.sv]
`timescale 1ns/1ns
module esp_link_checker (
	// Core clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Link wires
	input wire logic link_clk,
	input wire logic m_do,
	input wire logic m_oe,
	input wire logic e_do,
	input wire logic e_oe,
	input wire logic data_line
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// Cycles since the frame opened, saturating so old frames never wrap
	logic [9:0] age_q;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) age_q <= 10'h000;
		else if ($rose(m_oe)) age_q <= 10'h000;
		else if (age_q != 10'h3FF) age_q <= age_q + 10'h001;
	end
	one_driver_a: assert property (!(m_oe && e_oe)) else $error("line fight");
	clk_low_a: assert property ($fell(link_clk) |-> !link_clk [*5] ##1 link_clk)
		else $error("link low phase wrong");
	clk_high_a: assert property ($rose(link_clk) |-> link_clk [*5])
		else $error("link high phase short");
	frame_start_a: assert property ($rose(m_oe) |-> $fell(link_clk)) else $error("start");
	frame_end_a: assert property ($fell(m_oe) |-> $fell(link_clk)) else $error("end");
	m_shift_a: assert property (m_oe && $past(m_oe) && $changed(m_do) |-> $fell(link_clk))
		else $error("master data off edge");
	e_shift_a: assert property (e_oe && $past(e_oe) && $changed(e_do) |-> !link_clk)
		else $error("encoder data off edge");
	answer_wait_a: assert property ($rose(e_oe) |-> age_q >= 10'h091) else $error("early");
	e_release_a: assert property ($fell(e_oe) |-> link_clk && $past(link_clk, 8))
		else $error("encoder released early");
	cover property ($rose(e_oe));
	cover property ($fell(m_oe));
	cover property ($rose(m_oe) ##[1:20] m_do);
endmodule // esp_link_checker

// [dv/encoder_serial_position_link_bench.sv]
`timescale 1ns/1ns
module encoder_serial_position_link_bench;
	import esp_pkg::*;
	logic clk_in = 1'b0;
	logic arst_n_in, req_valid_in, rsp_ready_in, step_in, warn_in, ref_mark_in;
	logic req_ready_out, rsp_valid_out, cmd_err_out, busy_out;
	logic [5:0] req_mode_in;
	logic [1:0] req_sel_in;
	logic [23:0] req_param_in;
	logic [31:0] rsp_data_out;
	logic [31:0] exp_q[$];
	logic [7:0] rnd = 8'h32;
	logic [15:0] mv [4] = '{16'h0014, CMD_SET_NEWER, 16'h07D0, INTERP_X1};
	int bad_count, check_count, n;
	esp_link_if esp_link_if_i ();
	esp_master esp_master_i (.clk_in, .arst_n_in, .link(esp_link_if_i), .req_valid_in,
		.req_ready_out, .req_mode_in, .req_sel_in, .req_param_in, .pos_bits_in(6'h14),
		.rsp_valid_out, .rsp_ready_in, .rsp_data_out);
	esp_encoder esp_encoder_i (.clk_in, .arst_n_in, .link(esp_link_if_i), .step_in,
		.dir_pos_in(1'b1), .warn_in, .ref_mark_in, .factory_unlock_in(1'b0),
		.cmd_err_out, .busy_out);
	esp_link_checker esp_link_checker_i (.clk_in, .arst_n_in,
		.link_clk(esp_link_if_i.link_clk), .m_do(esp_link_if_i.m_do),
		.m_oe(esp_link_if_i.m_oe), .e_do(esp_link_if_i.e_do), .e_oe(esp_link_if_i.e_oe),
		.data_line(esp_link_if_i.data_line));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Expected word towards the user
	function automatic logic [31:0] w(input logic e, input logic [1:0] k, input logic [23:0] p);
		return {e, k, 5'h00, p};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic results;
		if (bad_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One request, held until the edge that takes it
	task automatic tr(input logic [5:0] m, input logic [1:0] s, input logic [23:0] p);
		int k;
		k = 0;
		@(negedge clk_in);
		while (req_ready_out !== 1'b1 && k < 3000) begin
			@(negedge clk_in);
			k++;
		end
		if (k == 3000) begin
			bad_count++;
			results;
		end
		req_valid_in = 1'b1;
		req_mode_in = m;
		req_sel_in = s;
		req_param_in = p;
		@(negedge clk_in);
		req_valid_in = 1'b0;
	endtask
	// Random stalls on the drain side
	always @(negedge clk_in) begin
		rnd <= lfsr(rnd);
		rsp_ready_in <= rnd[0];
	end
	// Oldest note is compared with each word taken
	always @(posedge clk_in) begin
		if (rsp_valid_out === 1'b1 && rsp_ready_in)
			chk(rsp_data_out, exp_q.size() ? exp_q.pop_front() : 'x);
	end
	initial begin
		{rnd, rsp_ready_in, arst_n_in, req_valid_in, step_in, warn_in, ref_mark_in} = {8'h32, 6'h02};
		{req_mode_in, req_sel_in, req_param_in} = 32'h0;
		{bad_count, check_count} = 0;
		repeat (8) @(negedge clk_in);
		arst_n_in = 1'b1;
		chk({30'h0, req_ready_out, rsp_valid_out}, 32'h2);
		repeat (5) begin
			@(negedge clk_in) {step_in, ref_mark_in} = 2'b11;
			@(negedge clk_in) {step_in, ref_mark_in} = 2'b00;
		end
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(w(0, KIND_MEM, {8'h00, mv[i]}));
			tr(MODE_MEM_RD, 2'h0, {6'h00, 2'(i), 16'h0000});
		end
		exp_q.push_back(w(0, KIND_POS, 24'h5));
		tr(MODE_POS, 2'h0, 24'h0);
		exp_q.push_back(w(0, KIND_POS, 24'h5));
		tr(MODE_POS_ADD, 2'h0, 24'h030000);
		exp_q.push_back(w(0, KIND_POS, 24'h5));
		exp_q.push_back(w(0, KIND_ADD1, {8'hC0, INTERP_X1}));
		tr(MODE_POS_ADD, 2'h1, 24'h030000);
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back(w(0, KIND_MEM, {8'h00, 16'hA5C3}));
			tr(MODE_MEM_WR, 2'h0, {4'h0, i ? 4'h8 : MEM_CMD_SET, 16'hA5C3});
			// Busy must show once the write is queued, before the frame closes
			for (n = 0; n < 1000 && busy_out !== 1'b1; n++) @(negedge clk_in);
			chk({31'h0, busy_out}, 32'h1);
			exp_q.push_back(w(0, KIND_MEM, {8'h00, i ? 16'hA5C3 : CMD_SET_NEWER}));
			tr(MODE_MEM_RD, 2'h0, {4'h0, i ? 4'h8 : MEM_CMD_SET, 16'h0000});
		end
		exp_q.push_back(w(1, KIND_POS, 24'h5));
		tr(6'h3F, 2'h0, 24'h0);
		// Error must stick, then the clear command must lift it
		for (int j = 0; j < 2; j++) begin
			for (n = 0; n < 3000 && exp_q.size() != 0; n++) @(negedge clk_in);
			if (n == 3000) bad_count++;
			chk({31'h0, cmd_err_out}, j ? 32'h0 : 32'h1);
			if (j == 0) begin
				exp_q.push_back(w(0, KIND_POS, 24'h5));
				tr(MODE_ERR_CLR, 2'h0, 24'h0);
			end
		end
		results;
	end
endmodule // encoder_serial_position_link_bench
